// ### hdl/cpc_console.sv
// Purpose: Operator console run control: clear, free run, sequence and phase stepping.
// Assumes: Panel inputs are levels; registers reached over classic Wishbone.
// Notes: Each sequence is four clock phases; sequence_one ends every instruction except a repeated store.
// Summary of operation
// - Clear down darkens every flip-flop lamp
// - Clear up enables the timing chain
// - Clear ignored while running high speed
// - Free-run up starts only if chain enabled
// - Run lamp lit while running, stops darken it
// - Sequence step runs to next sequence start
// - Sequence_one completes an instruction last, except a repeated store
// - Phase step press makes exactly one phase
// - Phase step needs single-phase enable up
// - No memory reference in phase-step mode
// - Select stop: jump, halt, light lamp
// - Stop code halts after next sequence_one
// - Select jump taken only with switch engaged
// - Single-phase lamp; idle step enters phase stepping
// - Manual set and clear per flip-flop
// - Phase lamp lit until next phase
// - Repeat re-executes instruction, address still advances
// - Repeat store 74 writes buffer, advances counter
// - Code 20 adds operand to accumulator
// - Repeat 76 stores accumulator through memory
// - Memory is 512 words of 15 bits
// - Held manual clear survives phase stepping
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module cpc_console
   import cpc_pkg::*;
#(
   parameter int P_PHASE_CYC = PHASE_CYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   // Panel switches
   input wire logic i_clr_dn,
   input wire logic i_clr_up,
   input wire logic i_run_up,
   input wire logic i_seq_step_dn,
   input wire logic i_phase_step_dn,
   input wire logic i_single_phase_enable_switch,
   input wire logic i_sel_stop_sw,
   input wire logic i_sel_jump_sw,
   input wire logic i_repeat_sw,
   input wire logic [N_MAN-1:0] i_man_set,
   input wire logic [N_MAN-1:0] i_man_clr,
   // Panel lamps
   output logic o_run_lamp,
   output logic o_stop_lamp,
   output logic o_sel_stop_lamp,
   output logic o_single_phase_lamp,
   output logic [3:0] o_phase_lamp,
   output logic [N_MAN-1:0] o_ff_lamp,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack
);
   typedef struct packed {
      logic [SW_W-1:0] sw_s1;
      logic [SW_W-1:0] sw_s2;
      logic [SW_W-1:0] sw_prev;
      cpc_mode_t mode;
      logic chain;
      logic [2:0] seq;
      logic [1:0] phase;
      logic [3:0] phase_lamp;
      logic stop_lamp;
      logic sel_lamp;
      logic pend_stop;
      logic pend_sel;
      logic [DATA_W-1:0] acc;
      logic [DATA_W-1:0] buf_q;
      logic [DATA_W-1:0] opnd;
      logic [ADDR_W-1:0] pc;
      logic [5:0] func;
      logic [2:0] jsub;
      logic [15:0] div;
      logic ack;
      logic [31:0] rdat;
   } cpc_state_t;

   cpc_state_t st_r;
   cpc_state_t st_nxt;
   logic [SW_W-1:0] sw_in;
   logic [SW_W-1:0] sw_rise;
   logic tick;
   logic seq_end;
   logic do_clr;
   logic mem_busy;
   logic mem_we;
   logic mem_re;
   logic [DATA_W-1:0] mem_wdata;
   logic [DATA_W-1:0] mem_rdata;
   logic [5:0] next_func;
   logic [DATA_W-1:0] wtmp;
   logic bus_wr;

   function automatic logic [DATA_W-1:0] wb_merge(input logic [DATA_W-1:0] old,
                                                  input logic [31:0] d,
                                                  input logic [3:0] s);
      logic [DATA_W-1:0] v;
      v = old;
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[DATA_W-1:8] = d[DATA_W-1:8];
      end
      return v;
   endfunction

   assign sw_in = {i_man_clr, i_man_set, i_repeat_sw, i_sel_jump_sw, i_sel_stop_sw,
                   i_single_phase_enable_switch, i_phase_step_dn, i_seq_step_dn,
                   i_run_up, i_clr_up, i_clr_dn};
   assign sw_rise = st_r.sw_s2 & ~st_r.sw_prev;
   assign mem_busy = (st_r.seq[SQ_ONE] | st_r.seq[SQ_FOUR]) & (st_r.phase != 2'd0);
   assign do_clr = sw_rise[SW_CLR_DN] & (st_r.mode != M_RUN);
   assign bus_wr = i_wb_cyc & i_wb_stb & i_wb_we & ~st_r.ack;
   assign mem_re = (st_r.mode != M_PSTEP);

   cpc_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
      .i_sys_clk(i_sys_clk),
      .i_addr(st_r.pc),
      .i_we(mem_we),
      .i_wdata(mem_wdata),
      .i_re(mem_re),
      .o_rdata(mem_rdata)
   );

   always_comb begin
      st_nxt = st_r;
      tick = 1'b0;
      seq_end = 1'b0;
      mem_we = 1'b0;
      mem_wdata = st_r.buf_q;
      next_func = st_r.func;
      wtmp = RST_WORD;
      st_nxt.sw_s1 = sw_in;
      st_nxt.sw_s2 = st_r.sw_s1;
      st_nxt.sw_prev = st_r.sw_s2;
      // Bus slave, one wait state
      st_nxt.ack = i_wb_cyc & i_wb_stb & ~st_r.ack;
      st_nxt.rdat = 32'h0000_0000;
      if (i_wb_cyc & i_wb_stb & ~i_wb_we & ~st_r.ack) begin
         case (i_wb_adr)
            REG_STATUS: begin
               st_nxt.rdat[ST_RUN] = (st_r.mode == M_RUN);
               st_nxt.rdat[ST_STOP] = st_r.stop_lamp;
               st_nxt.rdat[ST_SELSTOP] = st_r.sel_lamp;
               st_nxt.rdat[ST_SPLAMP] = st_r.sw_s2[SW_SP_EN];
               st_nxt.rdat[ST_CHAIN] = st_r.chain;
               st_nxt.rdat[ST_SEQ_LSB +: 3] = st_r.seq;
               st_nxt.rdat[ST_PHASE_LSB +: 4] = st_r.phase_lamp;
               st_nxt.rdat[ST_MODE_LSB +: 4] = st_r.mode;
            end
            REG_INSTR: st_nxt.rdat[8:0] = {st_r.func, st_r.jsub};
            REG_OPND: st_nxt.rdat[DATA_W-1:0] = st_r.opnd;
            REG_ACC: st_nxt.rdat[DATA_W-1:0] = st_r.acc;
            REG_PC: st_nxt.rdat[ADDR_W-1:0] = st_r.pc;
            REG_BUF: st_nxt.rdat[DATA_W-1:0] = st_r.buf_q;
            default: st_nxt.rdat = 32'h0000_0000;
         endcase
      end
      if (bus_wr) begin
         case (i_wb_adr)
            REG_INSTR: begin
               wtmp = wb_merge({6'h00, st_r.func, st_r.jsub}, i_wb_dat, i_wb_sel);
               st_nxt.func = wtmp[IR_F_LSB +: 6];
               st_nxt.jsub = wtmp[IR_J_LSB +: 3];
            end
            REG_OPND: st_nxt.opnd = wb_merge(st_r.opnd, i_wb_dat, i_wb_sel);
            REG_ACC: st_nxt.acc = wb_merge(st_r.acc, i_wb_dat, i_wb_sel);
            REG_PC: begin
               wtmp = wb_merge({6'h00, st_r.pc}, i_wb_dat, i_wb_sel);
               st_nxt.pc = wtmp[ADDR_W-1:0];
            end
            REG_BUF: st_nxt.buf_q = wb_merge(st_r.buf_q, i_wb_dat, i_wb_sel);
            default: st_nxt.pc = st_r.pc;
         endcase
      end
      // Panel switch actions
      if (st_r.mode == M_PSTEP && !st_r.sw_s2[SW_SP_EN]) begin
         st_nxt.mode = M_HALT;
      end
      if (do_clr) begin
         st_nxt.mode = M_HALT;
         st_nxt.chain = 1'b0;
         st_nxt.seq = 3'b000;
         st_nxt.phase = 2'd0;
         st_nxt.phase_lamp = 4'h0;
         st_nxt.stop_lamp = 1'b0;
         st_nxt.sel_lamp = 1'b0;
         st_nxt.pend_stop = 1'b0;
         st_nxt.pend_sel = 1'b0;
         st_nxt.acc = RST_WORD;
         st_nxt.buf_q = RST_WORD;
         st_nxt.opnd = RST_WORD;
         st_nxt.pc = '0;
         st_nxt.func = 6'h00;
         st_nxt.jsub = 3'h0;
         st_nxt.div = 16'h0000;
      end else if (sw_rise[SW_CLR_UP] && st_r.mode != M_RUN) begin
         st_nxt.chain = 1'b1;
      end else if (sw_rise[SW_RUN_UP] && st_r.chain && st_r.mode == M_HALT) begin
         st_nxt.mode = M_RUN;
         st_nxt.stop_lamp = 1'b0;
         st_nxt.sel_lamp = 1'b0;
      end else if (sw_rise[SW_SEQ_DN]) begin
         if (st_r.sw_s2[SW_SP_EN] && !mem_busy) begin
            st_nxt.mode = M_PSTEP;
         end else if (st_r.chain) begin
            st_nxt.mode = M_STEP;
            st_nxt.stop_lamp = 1'b0;
            st_nxt.sel_lamp = 1'b0;
         end
      end
      // Phase generation
      if (!do_clr && st_r.chain) begin
         if (st_r.mode == M_RUN || st_r.mode == M_STEP) begin
            if (st_r.div >= 16'(P_PHASE_CYC - 1)) begin
               st_nxt.div = 16'h0000;
               tick = 1'b1;
            end else begin
               st_nxt.div = st_r.div + 16'h0001;
            end
         end else if (st_r.mode == M_PSTEP) begin
            tick = sw_rise[SW_PH_DN];
         end
      end
      if (tick) begin
         st_nxt.phase_lamp = 4'b0001 << st_r.phase;
         st_nxt.phase = st_r.phase + 2'd1;
         seq_end = (st_r.phase == 2'd3);
      end
      if (seq_end) begin
         case (1'b1)
            st_r.seq[SQ_ONE]: begin
               if (!st_r.sw_s2[SW_REPEAT] && st_r.mode != M_PSTEP) begin
                  next_func = mem_rdata[IW_F_LSB +: 6];
                  st_nxt.func = next_func;
                  st_nxt.jsub = mem_rdata[IW_J_LSB +: 3];
                  st_nxt.opnd = {6'h00, mem_rdata[ADDR_W-1:0]};
                  st_nxt.buf_q = mem_rdata;
               end
               st_nxt.pc = st_r.pc + 9'd1;
               st_nxt.seq = (next_func == F_STR_Q || next_func == F_STR_A) ? 3'b100 : 3'b010;
               if (st_r.pend_stop || st_r.pend_sel) begin
                  st_nxt.mode = M_HALT;
                  st_nxt.stop_lamp = st_r.pend_stop;
                  st_nxt.sel_lamp = st_r.pend_sel;
                  st_nxt.pend_stop = 1'b0;
                  st_nxt.pend_sel = 1'b0;
               end
            end
            st_r.seq[SQ_THREE]: begin
               if (st_r.func == F_ADD) begin
                  st_nxt.acc = st_r.acc + st_r.opnd;
               end else if (st_r.func == F_JUMPS) begin
                  if (st_r.jsub == J_SEL_JUMP && st_r.sw_s2[SW_SEL_JUMP]) begin
                     st_nxt.pc = st_r.opnd[ADDR_W-1:0];
                  end else if (st_r.jsub == J_STOP) begin
                     st_nxt.pend_stop = 1'b1;
                  end else if (st_r.jsub == J_SEL_STOP && st_r.sw_s2[SW_SEL_STOP]) begin
                     st_nxt.pc = st_r.opnd[ADDR_W-1:0];
                     st_nxt.pend_sel = 1'b1;
                  end
               end
               st_nxt.seq = 3'b001;
            end
            st_r.seq[SQ_FOUR]: begin
               if (st_r.mode != M_PSTEP && (st_r.func == F_STR_Q || st_r.func == F_STR_A)) begin
                  mem_we = 1'b1;
                  mem_wdata = (st_r.func == F_STR_A) ? st_r.acc : st_r.buf_q;
               end
               if (st_r.sw_s2[SW_REPEAT]) begin
                  st_nxt.pc = st_r.pc + 9'd1;
                  st_nxt.seq = 3'b100;
               end else begin
                  st_nxt.seq = 3'b001;
               end
            end
            default: st_nxt.seq = st_r.seq;
         endcase
         if (st_r.mode == M_STEP) begin
            st_nxt.mode = M_HALT;
         end
      end
      // Manual pushbuttons, clear has the last word
      {st_nxt.seq, st_nxt.chain} = ({st_nxt.seq, st_nxt.chain} | st_r.sw_s2[SW_MSET +: N_MAN])
                                   & ~st_r.sw_s2[SW_MCLR +: N_MAN];
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         st_r <= '0;
         st_r.mode <= M_HALT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_run_lamp = (st_r.mode == M_RUN);
   assign o_stop_lamp = st_r.stop_lamp;
   assign o_sel_stop_lamp = st_r.sel_lamp;
   assign o_single_phase_lamp = st_r.sw_s2[SW_SP_EN];
   assign o_phase_lamp = st_r.phase_lamp;
   assign o_ff_lamp = {st_r.seq, st_r.chain};
   assign o_wb_dat = st_r.rdat;
   assign o_wb_ack = st_r.ack;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);

   a_clear_darkens: assert property (do_clr && st_r.sw_s2[SW_MSET +: N_MAN] == 4'h0
      |=> !st_r.chain && st_r.seq == 3'b000 && st_r.acc == RST_WORD && st_r.phase_lamp == 4'h0)
      else $error("clear left a lamp lit");
   a_clear_arms: assert property (sw_rise[SW_CLR_UP] && !sw_rise[SW_CLR_DN]
      && st_r.mode != M_RUN && !st_r.sw_s2[SW_MCLR] |=> st_r.chain)
      else $error("clear up did not enable chain");
   a_clear_ignored: assert property (st_r.mode == M_RUN && sw_rise[SW_CLR_DN]
      && !st_r.sw_s2[SW_MCLR] |=> st_r.chain == $past(st_r.chain))
      else $error("clear acted during high speed");
   a_run_start: assert property (st_r.mode == M_HALT && st_r.chain && sw_rise[SW_RUN_UP]
      && !sw_rise[SW_CLR_DN] && !sw_rise[SW_CLR_UP] |=> o_run_lamp)
      else $error("free run did not start");
   a_run_off: assert property (st_r.mode == M_RUN && sw_rise[SW_SEQ_DN]
      |=> !o_run_lamp)
      else $error("run lamp stayed on after step");
   a_step_halts: assert property (st_r.mode == M_STEP && seq_end && !sw_rise[SW_SEQ_DN]
      |=> st_r.mode == M_HALT ##1 st_r.phase == 2'd0 [*2])
      else $error("step did not halt at sequence start");
   a_one_last: assert property (seq_end && st_r.seq == 3'b010 && st_r.sw_s2[SW_MSET +: N_MAN] == 4'h0
      && st_r.sw_s2[SW_MCLR +: N_MAN] == 4'h0 |=> st_r.seq == 3'b001)
      else $error("sequence_one did not follow");
   a_phase_once: assert property (st_r.mode == M_PSTEP && st_r.chain && sw_rise[SW_PH_DN]
      && !do_clr |=> st_r.phase == $past(st_r.phase) + 2'd1)
      else $error("phase step did not give one phase");
   a_phase_idle: assert property (st_r.mode == M_PSTEP && !sw_rise[SW_PH_DN] && !do_clr
      |=> st_r.phase == $past(st_r.phase))
      else $error("phase advanced without a press");
   a_no_mem_pstep: assert property (st_r.mode == M_PSTEP |-> !mem_we && !mem_re)
      else $error("memory referenced in phase step");
   a_pstep_exit: assert property (st_r.mode == M_PSTEP && !st_r.sw_s2[SW_SP_EN]
      |=> st_r.mode != M_PSTEP)
      else $error("phase step survived disable");
   a_phase_lamp: assert property (tick |=> o_phase_lamp == (4'b0001 << $past(st_r.phase)))
      else $error("wrong phase lamp");
   a_hold_clear: assert property (st_r.sw_s2[SW_MCLR + 1] |=> !st_r.seq[SQ_ONE])
      else $error("manual clear lost");
   c_free_run: cover property (st_r.mode == M_HALT ##1 st_r.mode == M_RUN);
   c_phase_mode: cover property (st_r.mode == M_PSTEP && tick);
   c_sel_stop: cover property (!st_r.sel_lamp ##1 st_r.sel_lamp);
   c_repeat_store: cover property (mem_we && st_r.sw_s2[SW_REPEAT]);
endmodule
`default_nettype wire

// ### hdl/cpc_pkg.sv
// Purpose: Shared constants and types for the console run/step control.
// Assumes: 100 MHz system clock, one clock domain.
// Notes: Function codes are six bits and written in octal.
package cpc_pkg;
   localparam int DATA_W = 15;
   localparam int ADDR_W = 9;
   localparam int MEM_WORDS = 512;
   // Instruction fields
   localparam logic [5:0] F_ADD = 6'o20;
   localparam logic [5:0] F_JUMPS = 6'o15;
   localparam logic [5:0] F_STR_Q = 6'o74;
   localparam logic [5:0] F_STR_A = 6'o76;
   localparam logic [2:0] J_SEL_JUMP = 3'd1;
   localparam logic [2:0] J_STOP = 3'd2;
   localparam logic [2:0] J_SEL_STOP = 3'd3;
   localparam int IW_F_LSB = 9;
   localparam int IW_J_LSB = 6;
   // Register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_INSTR = 8'h04;
   localparam logic [7:0] REG_OPND = 8'h08;
   localparam logic [7:0] REG_ACC = 8'h0c;
   localparam logic [7:0] REG_PC = 8'h10;
   localparam logic [7:0] REG_BUF = 8'h14;
   // Status and instruction register fields
   localparam int ST_RUN = 0;
   localparam int ST_STOP = 1;
   localparam int ST_SELSTOP = 2;
   localparam int ST_SPLAMP = 3;
   localparam int ST_CHAIN = 4;
   localparam int ST_SEQ_LSB = 5;
   localparam int ST_PHASE_LSB = 8;
   localparam int ST_MODE_LSB = 12;
   localparam int IR_J_LSB = 0;
   localparam int IR_F_LSB = 3;
   // Sequence designator bits
   localparam int SQ_ONE = 0;
   localparam int SQ_THREE = 1;
   localparam int SQ_FOUR = 2;
   // Panel input vector positions
   localparam int SW_CLR_DN = 0;
   localparam int SW_CLR_UP = 1;
   localparam int SW_RUN_UP = 2;
   localparam int SW_SEQ_DN = 3;
   localparam int SW_PH_DN = 4;
   localparam int SW_SP_EN = 5;
   localparam int SW_SEL_STOP = 6;
   localparam int SW_SEL_JUMP = 7;
   localparam int SW_REPEAT = 8;
   localparam int SW_MSET = 9;
   localparam int SW_MCLR = 13;
   localparam int N_MAN = 4;
   localparam int SW_W = 17;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PHASE_TIME_NS = 500;
   localparam int PHASE_CYC = PHASE_TIME_NS / CLK_PERIOD_NS;
   localparam logic [DATA_W-1:0] RST_WORD = 15'h0000;
   typedef enum logic [3:0] {
      M_HALT = 4'b0001,
      M_RUN = 4'b0010,
      M_STEP = 4'b0100,
      M_PSTEP = 4'b1000
   } cpc_mode_t;
endpackage

// ### hdl/cpc_mem.sv
// Purpose: Main store, single port, registered read data.
// Assumes: Write and read address are the same program counter.
// Notes: Read data holds while the read enable is low.
`timescale 1ns/1ps
`default_nettype none
module cpc_mem #(
   parameter int AW = 9,
   parameter int DW = 15
) (
   // Clock
   input wire logic i_sys_clk,
   // Access
   input wire logic [AW-1:0] i_addr,
   input wire logic i_we,
   input wire logic [DW-1:0] i_wdata,
   input wire logic i_re,
   output logic [DW-1:0] o_rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_sys_clk) begin
      if (i_we) begin
         mem[i_addr] <= i_wdata;
      end
      if (i_re) begin
         o_rdata <= mem[i_addr];
      end
   end
endmodule
`default_nettype wire

// ### sim/cpc_panel_op.sv
// Purpose: Operator model for the switch and lamp panel.
// Assumes: Switch levels change just after a rising clock edge.
// Notes: Presses and releases last 4 cycles, longer than the input sync.
`timescale 1ns/1ps
`default_nettype none
module cpc_panel_op
   import cpc_pkg::*;
(
   // Clock
   input wire logic i_sys_clk,
   // Switch levels
   output logic [SW_W-1:0] o_sw
);
   initial begin
      o_sw = '0;
   end
   task automatic press(input int idx);
      @(posedge i_sys_clk);
      o_sw[idx] <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      o_sw[idx] <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
   endtask
   task automatic hold(input int idx, input logic v);
      @(posedge i_sys_clk);
      o_sw[idx] <= v;
   endtask
   // Force flip-flops to mask: set ones, clear the rest
   task automatic manual(input logic [N_MAN-1:0] m);
      @(posedge i_sys_clk);
      o_sw[SW_MSET +: N_MAN] <= m;
      o_sw[SW_MCLR +: N_MAN] <= ~m;
      repeat (5) @(posedge i_sys_clk);
      o_sw[SW_MSET +: N_MAN] <= '0;
      o_sw[SW_MCLR +: N_MAN] <= '0;
      repeat (3) @(posedge i_sys_clk);
   endtask
endmodule
`default_nettype wire

// ### sim/cpc_console_tb.sv
// Purpose: Self-checking bench for the console run control.
// Assumes: Phase length shortened to 4 cycles.
// Notes: Memory is loaded through repeat-store before any program runs.
`timescale 1ns/1ps
`default_nettype none
module console_run_step_control_tb;
   import cpc_pkg::*;
   localparam logic [14:0] PAT = 15'h2a5b;
   logic clk, rst_n, cyc, stb, we, ack;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, d;
   logic [3:0] sel, phase_lamp, ff_lamp, p;
   logic run_lamp, stop_lamp, sel_stop_lamp, sp_lamp;
   logic [8:0] a, na;
   wire [SW_W-1:0] sw;
   int bad_count, comparisons;
   logic [14:0] prog [0:5] = '{{F_ADD, 9'd5}, {F_JUMPS, J_STOP, 6'd0}, {F_ADD, 9'd5},
      {F_JUMPS, J_SEL_JUMP, 6'd0}, {F_JUMPS, J_SEL_STOP, 6'd0}, {F_ADD, 9'd5}};
   logic [8:0] ld_adr [0:5] = '{9'h001, 9'h002, 9'h003, 9'h004, 9'h040, 9'h0c0};
   logic [8:0] addrs [0:2] = '{9'h000, 9'h0aa, 9'h1ff};

   cpc_panel_op panel (.i_sys_clk(clk), .o_sw(sw));
   cpc_console #(.P_PHASE_CYC(4)) u_dut (
      .i_sys_clk(clk), .i_reset_n(rst_n),
      .i_clr_dn(sw[SW_CLR_DN]), .i_clr_up(sw[SW_CLR_UP]), .i_run_up(sw[SW_RUN_UP]),
      .i_seq_step_dn(sw[SW_SEQ_DN]), .i_phase_step_dn(sw[SW_PH_DN]),
      .i_single_phase_enable_switch(sw[SW_SP_EN]), .i_sel_stop_sw(sw[SW_SEL_STOP]),
      .i_sel_jump_sw(sw[SW_SEL_JUMP]), .i_repeat_sw(sw[SW_REPEAT]),
      .i_man_set(sw[SW_MSET +: N_MAN]), .i_man_clr(sw[SW_MCLR +: N_MAN]),
      .o_run_lamp(run_lamp), .o_stop_lamp(stop_lamp), .o_sel_stop_lamp(sel_stop_lamp),
      .o_single_phase_lamp(sp_lamp), .o_phase_lamp(phase_lamp), .o_ff_lamp(ff_lamp),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
      .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic close_out;
      $display("mismatches %0d, comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   // One classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= wd;
      sel <= 4'hf;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         $display("unexpected bus ack: expected 1, seen none");
      end
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wait_halt;
      int n;
      n = 0;
      do begin
         wb(1'b0, REG_STATUS, 32'h0);
         n++;
      end while (d[ST_MODE_LSB] !== 1'b1 && n < 500);
      if (n >= 500) begin
         bad_count++;
         $display("unexpected halt: expected 1, seen 0");
      end
   endtask

   task automatic step;
      panel.press(SW_SEQ_DN);
      wait_halt();
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      wdat = 32'h0;
      sel = 4'h0;
      bad_count = 0;
      comparisons = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status", 32'h1000, d);
      wb(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, d);
      // Load program by repeated store of the buffer word
      panel.hold(SW_REPEAT, 1'b1);
      wb(1'b1, REG_INSTR, {23'd0, F_STR_Q, 3'd0});
      panel.manual(4'b1001);
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, REG_PC, {23'd0, ld_adr[i]});
         wb(1'b1, REG_BUF, {17'd0, prog[i]});
         step();
         wb(1'b0, REG_PC, 32'h0);
         chk("pc", {23'd0, ld_adr[i] + 9'd1}, d);
         chk("ff lamps", 32'h9, 32'(ff_lamp));
      end
      panel.hold(SW_REPEAT, 1'b0);
      panel.press(SW_CLR_DN);
      chk("ff lamps", 32'h0, 32'(ff_lamp));
      panel.press(SW_RUN_UP);
      chk("run lamp", 32'h0, 32'(run_lamp));
      panel.press(SW_CLR_UP);
      chk("ff lamps", 32'h1, 32'(ff_lamp));
      // Run: add 5, then stop code halts after next fetch
      wb(1'b1, REG_PC, 32'h1);
      panel.manual(4'b0011);
      panel.press(SW_RUN_UP);
      chk("run lamp", 32'h1, 32'(run_lamp));
      wait_halt();
      wb(1'b0, REG_ACC, 32'h0);
      chk("acc", 32'h5, d);
      chk("stop lamp", 32'h1, 32'(stop_lamp));
      chk("run lamp", 32'h0, 32'(run_lamp));
      wb(1'b0, REG_PC, 32'h0);
      chk("pc", 32'h4, d);
      // Select jump to 040, select stop there jumps to 0c0 and halts after its fetch
      panel.hold(SW_SEL_JUMP, 1'b1);
      panel.hold(SW_SEL_STOP, 1'b1);
      panel.press(SW_RUN_UP);
      wait_halt();
      wb(1'b0, REG_PC, 32'h0);
      chk("pc", 32'h0c1, d);
      chk("sel stop lamp", 32'h1, 32'(sel_stop_lamp));
      chk("stop lamp", 32'h0, 32'(stop_lamp));
      wb(1'b0, REG_ACC, 32'h0);
      chk("acc", 32'ha, d);
      // Phase stepping
      p = phase_lamp;
      panel.press(SW_PH_DN);
      chk("phase lamp", 32'(p), 32'(phase_lamp));
      panel.hold(SW_SP_EN, 1'b1);
      repeat (4) @(posedge clk);
      chk("sp lamp", 32'h1, 32'(sp_lamp));
      panel.press(SW_SEQ_DN);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("pstep mode", 32'h1, 32'(d[ST_MODE_LSB + 3]));
      for (int k = 0; k < 5; k++) begin
         panel.press(SW_PH_DN);
         p = (p == 4'h0) ? 4'h1 : {p[2:0], p[3]};
         chk("phase lamp", 32'(p), 32'(phase_lamp));
      end
      panel.hold(SW_MCLR + 1, 1'b1);
      panel.hold(SW_MCLR + 2, 1'b1);
      repeat (3) panel.press(SW_PH_DN);
      panel.hold(SW_MCLR + 1, 1'b0);
      panel.hold(SW_MCLR + 2, 1'b0);
      chk("seq lamps", 32'h0, 32'(ff_lamp[2:1]));
      panel.hold(SW_SP_EN, 1'b0);
      repeat (4) @(posedge clk);
      chk("sp lamp", 32'h0, 32'(sp_lamp));
      p = phase_lamp;
      panel.press(SW_PH_DN);
      chk("phase lamp", 32'(p), 32'(phase_lamp));
      // Repeat store of accumulator across the whole memory
      panel.press(SW_CLR_DN);
      panel.hold(SW_REPEAT, 1'b1);
      wb(1'b1, REG_INSTR, {23'd0, F_STR_A, 3'd0});
      wb(1'b1, REG_ACC, {17'd0, PAT});
      panel.manual(4'b1001);
      panel.press(SW_RUN_UP);
      panel.press(SW_CLR_DN);
      chk("chain lamp", 32'h1, 32'(ff_lamp[0]));
      chk("run lamp", 32'h1, 32'(run_lamp));
      repeat (9000) @(posedge clk);
      panel.press(SW_SEQ_DN);
      chk("run lamp", 32'h0, 32'(run_lamp));
      wait_halt();
      panel.hold(SW_REPEAT, 1'b0);
      panel.press(SW_CLR_DN);
      for (int i = 0; i < 3; i++) begin
         a = addrs[i];
         na = a + 9'd1;
         wb(1'b1, REG_PC, {23'd0, a});
         panel.manual(4'b0011);
         step();
         wb(1'b0, REG_BUF, 32'h0);
         chk("fetched word", {17'd0, PAT}, d);
         wb(1'b0, REG_PC, 32'h0);
         chk("pc", {23'd0, na}, d);
      end
      close_out();
   end
endmodule
`default_nettype wire
